// ---- design/slfe_serial_rx.sv ----
/*
 * Package of shared constants for the serial LCD RAM front end, followed by the
 * serial receiver that runs on the host's serial clock.
 * Assumes the host keeps chip select low for a whole byte and that the serial
 * clock only toggles while chip select is low.
 */
package slfe_pkg;
   localparam int BYTE_BITS = 8;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam int PAGES = 9;
   localparam int COLUMNS = 132;
   localparam logic [3:0] PAGE_ICON = 4'h8;
   localparam logic [7:0] COL_MAX = 8'h83;
   localparam logic [5:0] VOL_DEFAULT = 6'h20;
   // Command codes and the masks that select their fixed bits.
   localparam logic [7:0] M_BIT0 = 8'hfe;
   localparam logic [7:0] M_NIB = 8'hf0;
   localparam logic [7:0] M_LINE = 8'hc0;
   localparam logic [7:0] M_COM = 8'hf7;
   localparam logic [7:0] M_3BIT = 8'hf8;
   localparam logic [7:0] C_DISP = 8'hae;
   localparam logic [7:0] C_LINE = 8'h40;
   localparam logic [7:0] C_PAGE = 8'hb0;
   localparam logic [7:0] C_COL_HI = 8'h10;
   localparam logic [7:0] C_COL_LO = 8'h00;
   localparam logic [7:0] C_ADC = 8'ha0;
   localparam logic [7:0] C_INV = 8'ha6;
   localparam logic [7:0] C_ALLON = 8'ha4;
   localparam logic [7:0] C_BIAS = 8'ha2;
   localparam logic [7:0] C_RMW = 8'he0;
   localparam logic [7:0] C_END = 8'hee;
   localparam logic [7:0] C_RESET = 8'he2;
   localparam logic [7:0] C_COM = 8'hc0;
   localparam logic [7:0] C_POWER = 8'h28;
   localparam logic [7:0] C_RATIO = 8'h20;
   localparam logic [7:0] C_VOLUME = 8'h81;
   localparam logic [7:0] C_STATIC = 8'hac;
   localparam logic [7:0] C_BOOST = 8'hf8;
   localparam logic [7:0] C_TEST = 8'hf0;
   localparam logic [6:0] ROWS_LAST = 7'h40;
   typedef enum logic [1:0] {ARG_NONE, ARG_VOLUME, ARG_STATIC, ARG_BOOST} slfe_arg_t;
endpackage : slfe_pkg

module slfe_serial_rx (
   input wire logic scl,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic dc_sel,
   output logic [7:0] byte_out,
   output logic dc_out,
   output logic byte_toggle
);
   typedef struct packed {
      logic [6:0] shift;
      logic [2:0] cnt;
   } slfe_frame_t;
   typedef struct packed {
      logic [7:0] data;
      logic dc;
      logic tog;
   } slfe_hand_t;

   slfe_frame_t f_q, f_d;
   slfe_hand_t h_q, h_d;
   logic frame_rst_n;

   // Chip select high holds the frame state in reset; the handed-over byte
   // and its toggle survive so the core never sees a false byte event.
   assign frame_rst_n = reset_n & ~cs_n;

   always_comb begin
      f_d = f_q;
      h_d = h_q;
      f_d.shift = {f_q.shift[5:0], sdi};
      f_d.cnt = f_q.cnt + 3'h1;
      if (f_q.cnt == slfe_pkg::BIT_LAST) begin
         h_d.data = {f_q.shift, sdi};
         h_d.dc = dc_sel;
         h_d.tog = ~h_q.tog;
      end
   end

   always_ff @(posedge scl or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         f_q <= '0;
      end else begin
         f_q <= f_d;
      end
   end

   always_ff @(posedge scl or negedge reset_n) begin
      if (!reset_n) begin
         h_q <= '0;
      end else begin
         h_q <= h_d;
      end
   end

   assign byte_out = h_q.data;
   assign dc_out = h_q.dc;
   assign byte_toggle = h_q.tog;

   chk_byte_eighth: assert property (@(posedge scl) disable iff (!frame_rst_n)
      f_q.cnt == slfe_pkg::BIT_LAST |=> h_q.tog != $past(h_q.tog) &&
      h_q.data == $past({f_q.shift, sdi}))
      else $error("byte not handed over on the eighth edge");
   chk_counter_wrap: assert property (@(posedge scl) disable iff (!frame_rst_n)
      f_q.cnt == slfe_pkg::BIT_LAST |=> f_q.cnt == 3'h0 ##7 f_q.cnt == slfe_pkg::BIT_LAST)
      else $error("bit counter did not restart after a byte");
endmodule : slfe_serial_rx

// ---- design/slfe_frontend.sv ----
/*
 * Top of the serial LCD RAM front end: serial receiver on the host clock,
 * command decode, display RAM with a separate refresh port, reset defaults
 * and a small line and frame timing generator on the core clock.
 * Assumes the host keeps at least one byte time between bytes, which is
 * longer than the three core cycles the byte handover needs.
 */
module slfe_frontend #(
   parameter int LINE_CYCLES = 16,
   parameter int NPAGES = slfe_pkg::PAGES,
   parameter int NCOLS = slfe_pkg::COLUMNS
) (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic SCL,
   input wire logic CS_N,
   input wire logic SDI,
   input wire logic DATA_COMMAND_SELECT,
   input wire logic [3:0] REFRESH_PAGE,
   input wire logic [7:0] REFRESH_SEG,
   output logic [7:0] REFRESH_DATA,
   output logic DISPLAY_ON,
   output logic DISPLAY_INVERSE,
   output logic SEG_REVERSE,
   output logic ALL_POINTS_ON,
   output logic BIAS_SEL,
   output logic [2:0] POWER_CTRL,
   output logic [2:0] RESISTOR_RATIO,
   output logic [5:0] VOLUME,
   output logic VOLUME_MODE,
   output logic STATIC_ON,
   output logic [1:0] STATIC_MODE,
   output logic RMW_ON,
   output logic COM_REVERSE,
   output logic [5:0] START_LINE,
   output logic [3:0] PAGE_ADDR,
   output logic [7:0] COL_ADDR,
   output logic TEST_MODE,
   output logic [1:0] BOOSTER,
   output logic LINE_LATCH_PULSE,
   output logic LCD_POLARITY_TOGGLE,
   output logic STATIC_DRIVE_PHASE,
   output logic BLANKING_OUTPUT
);
   typedef struct packed {
      logic [2:0] sync;
      slfe_pkg::slfe_arg_t arg;
      logic disp_on;
      logic inverse;
      logic adc;
      logic allon;
      logic bias;
      logic [2:0] power;
      logic [2:0] ratio;
      logic [5:0] volume;
      logic static_on;
      logic [1:0] static_reg;
      logic rmw;
      logic com_rev;
      logic [5:0] start_line;
      logic [3:0] page;
      logic [7:0] col;
      logic test;
      logic [1:0] boost;
      logic [7:0] line_cnt;
      logic [6:0] row_cnt;
      logic line_pulse;
      logic polarity;
      logic static_phase;
      logic blank;
      logic vol_mode;
   } slfe_core_t;

   localparam slfe_core_t CORE_RESET = '{
      sync: 3'h0,
      arg: slfe_pkg::ARG_NONE,
      disp_on: 1'b0,
      inverse: 1'b0,
      adc: 1'b0,
      allon: 1'b0,
      bias: 1'b0,
      power: 3'h0,
      ratio: 3'h0,
      volume: slfe_pkg::VOL_DEFAULT,
      static_on: 1'b0,
      static_reg: 2'h0,
      rmw: 1'b0,
      com_rev: 1'b0,
      start_line: 6'h0,
      page: 4'h0,
      col: 8'h0,
      test: 1'b0,
      boost: 2'h0,
      line_cnt: 8'h0,
      row_cnt: 7'h0,
      line_pulse: 1'b1,
      polarity: 1'b1,
      static_phase: 1'b1,
      blank: 1'b1,
      vol_mode: 1'b0
   };

   localparam logic [7:0] LINE_LAST = 8'(LINE_CYCLES - 1);

   slfe_core_t q, d;
   logic [7:0] rx_byte;
   logic rx_dc;
   logic rx_tog;
   logic new_byte;
   logic ram_we;
   logic [7:0] ram_wdata;
   logic [7:0] rd_q;
   logic [7:0] ram [NPAGES][NCOLS];
   logic [7:0] rd_col;

   // Only a write path exists; nothing in this block drives data back to the host.
   slfe_serial_rx slfe_serial_rx_i (
      .scl(SCL),
      .reset_n(RESET_N),
      .cs_n(CS_N),
      .sdi(SDI),
      .dc_sel(DATA_COMMAND_SELECT),
      .byte_out(rx_byte),
      .dc_out(rx_dc),
      .byte_toggle(rx_tog)
   );

   // The byte and select bits are stable for a whole byte time after the
   // toggle moves, so they are read once the synchronised toggle arrives.
   assign new_byte = q.sync[2] ^ q.sync[1];

   always_comb begin
      d = q;
      ram_we = 1'b0;
      ram_wdata = rx_byte;
      d.sync = {q.sync[1:0], rx_tog};
      if (new_byte) begin
         if (rx_dc) begin
            if (q.page < 4'(NPAGES) && q.col <= slfe_pkg::COL_MAX) begin
               ram_we = 1'b1;
            end
            if (q.page == slfe_pkg::PAGE_ICON) begin
               ram_wdata = {7'h0, rx_byte[0]};
            end
            if (q.col < slfe_pkg::COL_MAX) begin
               d.col = q.col + 8'h01;
            end
         end else begin
            case (q.arg)
               slfe_pkg::ARG_VOLUME: begin
                  d.volume = rx_byte[5:0];
                  d.arg = slfe_pkg::ARG_NONE;
               end
               slfe_pkg::ARG_STATIC: begin
                  d.static_reg = rx_byte[1:0];
                  d.arg = slfe_pkg::ARG_NONE;
               end
               slfe_pkg::ARG_BOOST: begin
                  d.boost = rx_byte[1:0];
                  d.arg = slfe_pkg::ARG_NONE;
               end
               slfe_pkg::ARG_NONE: begin
                  if ((rx_byte & slfe_pkg::M_BIT0) == slfe_pkg::C_DISP) begin
                     d.disp_on = rx_byte[0];
                  end else if ((rx_byte & slfe_pkg::M_LINE) == slfe_pkg::C_LINE) begin
                     d.start_line = rx_byte[5:0];
                  end else if ((rx_byte & slfe_pkg::M_NIB) == slfe_pkg::C_PAGE) begin
                     d.page = rx_byte[3:0];
                  end else if ((rx_byte & slfe_pkg::M_NIB) == slfe_pkg::C_COL_HI) begin
                     d.col[7:4] = rx_byte[3:0];
                  end else if ((rx_byte & slfe_pkg::M_NIB) == slfe_pkg::C_COL_LO) begin
                     d.col[3:0] = rx_byte[3:0];
                  end else if ((rx_byte & slfe_pkg::M_BIT0) == slfe_pkg::C_ADC) begin
                     d.adc = rx_byte[0];
                  end else if ((rx_byte & slfe_pkg::M_BIT0) == slfe_pkg::C_INV) begin
                     d.inverse = rx_byte[0];
                  end else if ((rx_byte & slfe_pkg::M_BIT0) == slfe_pkg::C_ALLON) begin
                     d.allon = rx_byte[0];
                  end else if ((rx_byte & slfe_pkg::M_BIT0) == slfe_pkg::C_BIAS) begin
                     d.bias = rx_byte[0];
                  end else if (rx_byte == slfe_pkg::C_RMW) begin
                     d.rmw = 1'b1;
                  end else if (rx_byte == slfe_pkg::C_END) begin
                     d.rmw = 1'b0;
                  end else if (rx_byte == slfe_pkg::C_RESET) begin
                     // Soft reset leaves display, inversion, segment direction, power and bias.
                     d.rmw = CORE_RESET.rmw;
                     d.static_on = CORE_RESET.static_on;
                     d.static_reg = CORE_RESET.static_reg;
                     d.start_line = CORE_RESET.start_line;
                     d.col = CORE_RESET.col;
                     d.page = CORE_RESET.page;
                     d.com_rev = CORE_RESET.com_rev;
                     d.volume = CORE_RESET.volume;
                     d.test = CORE_RESET.test;
                  end else if ((rx_byte & slfe_pkg::M_COM) == slfe_pkg::C_COM) begin
                     d.com_rev = rx_byte[3];
                  end else if ((rx_byte & slfe_pkg::M_3BIT) == slfe_pkg::C_POWER) begin
                     d.power = rx_byte[2:0];
                  end else if ((rx_byte & slfe_pkg::M_3BIT) == slfe_pkg::C_RATIO) begin
                     d.ratio = rx_byte[2:0];
                  end else if (rx_byte == slfe_pkg::C_VOLUME) begin
                     d.arg = slfe_pkg::ARG_VOLUME;
                  end else if ((rx_byte & slfe_pkg::M_BIT0) == slfe_pkg::C_STATIC) begin
                     d.static_on = rx_byte[0];
                     d.arg = slfe_pkg::ARG_STATIC;
                  end else if (rx_byte == slfe_pkg::C_BOOST) begin
                     d.arg = slfe_pkg::ARG_BOOST;
                  end else if ((rx_byte & slfe_pkg::M_NIB) == slfe_pkg::C_TEST) begin
                     d.test = 1'b1;
                  end
               end
               default: begin
                  d.arg = slfe_pkg::ARG_NONE;
               end
            endcase
         end
      end
      // Line and frame timing only runs out of reset; under reset it holds high.
      d.line_pulse = 1'b0;
      d.line_cnt = q.line_cnt + 8'h01;
      if (q.line_cnt == LINE_LAST) begin
         d.line_cnt = 8'h0;
         d.line_pulse = 1'b1;
         d.row_cnt = q.row_cnt + 7'h01;
         if (q.row_cnt == slfe_pkg::ROWS_LAST) begin
            d.row_cnt = 7'h0;
            d.polarity = ~q.polarity;
         end
      end
      d.static_phase = q.static_on & q.polarity;
      d.blank = q.disp_on;
      d.vol_mode = (d.arg == slfe_pkg::ARG_VOLUME);
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         q <= CORE_RESET;
      end else begin
         q <= d;
      end
   end

   // Refresh readout sees the RAM through its own port, so host writes
   // arriving at any time cannot disturb what is being scanned out.
   assign rd_col = SEG_REVERSE ? 8'(NCOLS - 1) - REFRESH_SEG : REFRESH_SEG;

   always_ff @(posedge CLK) begin
      if (ram_we) begin
         ram[q.page][q.col] <= ram_wdata;
      end
      if (REFRESH_PAGE < 4'(NPAGES) && rd_col < 8'(NCOLS)) begin
         rd_q <= ram[REFRESH_PAGE][rd_col];
      end else begin
         rd_q <= 8'h0;
      end
   end

   assign REFRESH_DATA = rd_q;
   assign DISPLAY_ON = q.disp_on;
   assign DISPLAY_INVERSE = q.inverse;
   assign SEG_REVERSE = q.adc;
   assign ALL_POINTS_ON = q.allon;
   assign BIAS_SEL = q.bias;
   assign POWER_CTRL = q.power;
   assign RESISTOR_RATIO = q.ratio;
   assign VOLUME = q.volume;
   assign VOLUME_MODE = q.vol_mode;
   assign STATIC_ON = q.static_on;
   assign STATIC_MODE = q.static_reg;
   assign RMW_ON = q.rmw;
   assign COM_REVERSE = q.com_rev;
   assign START_LINE = q.start_line;
   assign PAGE_ADDR = q.page;
   assign COL_ADDR = q.col;
   assign TEST_MODE = q.test;
   assign BOOSTER = q.boost;
   assign LINE_LATCH_PULSE = q.line_pulse;
   assign LCD_POLARITY_TOGGLE = q.polarity;
   assign STATIC_DRIVE_PHASE = q.static_phase;
   assign BLANKING_OUTPUT = q.blank;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);

   chk_col_increment: assert property (
      new_byte && rx_dc && q.col < slfe_pkg::COL_MAX |=> q.col == $past(q.col) + 8'h01)
      else $error("column did not advance after a data byte");
   chk_col_saturate: assert property (
      new_byte && rx_dc && q.col == slfe_pkg::COL_MAX |=> q.col == slfe_pkg::COL_MAX)
      else $error("column moved past its last address");
   chk_page_hold: assert property (
      new_byte && rx_dc |=> $stable(q.page))
      else $error("page changed on a data byte");
   chk_icon_bit: assert property (
      ram_we && q.page == slfe_pkg::PAGE_ICON |-> ram_wdata[7:1] == 7'h0)
      else $error("icon page stored more than bit 0");
   chk_command_nowrite: assert property (
      new_byte && !rx_dc |-> !ram_we ##1 $stable(q.col) || q.arg == slfe_pkg::ARG_NONE)
      else $error("command byte reached the RAM");
   chk_soft_reset: assert property (
      new_byte && !rx_dc && q.arg == slfe_pkg::ARG_NONE && rx_byte == slfe_pkg::C_RESET
      |=> q.col == 8'h0 && q.page == 4'h0 && q.volume == slfe_pkg::VOL_DEFAULT &&
      q.disp_on == $past(q.disp_on) && q.power == $past(q.power))
      else $error("soft reset applied the wrong defaults");
   chk_reset_defaults: assert property (
      $rose(RESET_N) |-> !DISPLAY_ON && BLANKING_OUTPUT && LINE_LATCH_PULSE &&
      VOLUME == slfe_pkg::VOL_DEFAULT ##2 !BLANKING_OUTPUT)
      else $error("reset defaults not seen after release");
   // Data bytes must reach the RAM only inside the array; address commands must load their own field.
   chk_data_write: assert property (
      new_byte && rx_dc && q.page < 4'(NPAGES) && q.col <= slfe_pkg::COL_MAX |-> ram_we)
      else $error("data byte did not reach the RAM");
   chk_ram_range: assert property (
      ram_we |-> q.page < 4'(NPAGES) && q.col <= slfe_pkg::COL_MAX)
      else $error("RAM write outside the array");
   chk_page_load: assert property (
      new_byte && !rx_dc && q.arg == slfe_pkg::ARG_NONE &&
      (rx_byte & slfe_pkg::M_NIB) == slfe_pkg::C_PAGE |=> q.page == $past(rx_byte[3:0]))
      else $error("page command loaded the wrong page");
   chk_col_upper: assert property (
      new_byte && !rx_dc && q.arg == slfe_pkg::ARG_NONE &&
      (rx_byte & slfe_pkg::M_NIB) == slfe_pkg::C_COL_HI |=> q.col[7:4] == $past(rx_byte[3:0]))
      else $error("upper column nibble not loaded");
   chk_col_lower: assert property (
      new_byte && !rx_dc && q.arg == slfe_pkg::ARG_NONE &&
      (rx_byte & slfe_pkg::M_NIB) == slfe_pkg::C_COL_LO |=> q.col[3:0] == $past(rx_byte[3:0]))
      else $error("lower column nibble not loaded");
   chk_volume_arg: assert property (
      new_byte && !rx_dc && q.arg == slfe_pkg::ARG_VOLUME
      |=> q.volume == $past(rx_byte[5:0]) && !VOLUME_MODE)
      else $error("volume argument not taken");
   chk_soft_keep: assert property (
      new_byte && !rx_dc && q.arg == slfe_pkg::ARG_NONE && rx_byte == slfe_pkg::C_RESET
      |=> q.adc == $past(q.adc) && q.inverse == $past(q.inverse) && q.bias == $past(q.bias))
      else $error("soft reset touched a kept setting");
   chk_line_pulse: assert property (
      q.line_cnt == LINE_LAST |=> LINE_LATCH_PULSE && q.line_cnt == 8'h0)
      else $error("line pulse missing at the end of a line");
   chk_polarity_hold: assert property (
      !(q.line_cnt == LINE_LAST && q.row_cnt == slfe_pkg::ROWS_LAST)
      |=> $stable(LCD_POLARITY_TOGGLE))
      else $error("polarity changed inside a frame");
endmodule : slfe_frontend

// ---- testbench/slfe_host_model.sv ----
/*
 * Behavioural host that writes bytes into the serial port of the front end.
 * Assumes the bench calls its tasks one at a time from a single process.
 */
module slfe_host_model (
   output logic scl,
   output logic cs_n,
   output logic sdi,
   output logic dc
);
   timeunit 1ns;
   timeprecision 1ps;

   // The serial clock idles high and runs at 12 ns inside a frame; partial also runs it after chip select rises.
   initial begin
      scl = 1'h1;
      cs_n = 1'h1;
      sdi = 1'h0;
      dc = 1'h0;
   end

   // Sends one byte; select is held through the eighth rise, then scrambled.
   task automatic send(input logic [7:0] b, input logic is_data, input logic last);
      #7 cs_n = 1'h0;
      #20;
      for (int i = 7; i >= 0; i--) begin
         scl = 1'h0;
         sdi = b[i];
         dc = is_data;
         #6 scl = 1'h1;
         #6;
      end
      #10 sdi = ~sdi;
      dc = ~dc;
      if (last) cs_n = 1'h1;
      #400;
   endtask : send

   // Three bits of a byte, then chip select rises and the clock keeps toggling.
   task automatic partial();
      #7 cs_n = 1'h0;
      #20;
      for (int i = 0; i < 7; i++) begin
         scl = 1'h0;
         sdi = i[0];
         #6 scl = 1'h1;
         #6;
         if (i == 2) cs_n = 1'h1;
      end
      sdi = ~sdi;
      #400;
   endtask : partial
endmodule : slfe_host_model

// ---- testbench/serial_lcd_ram_frontend_tb.sv ----
/*
 * Self-checking bench for the serial LCD RAM front end.
 * Assumes the host model drives the serial pins; the bench owns clock,
 * reset and the refresh port, and a watcher compares queued notes.
 */
module serial_lcd_ram_frontend_tb;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic on, inv, rev, all, bias;
      logic [2:0] pwr, ratio;
      logic [5:0] vol;
      logic vm, st;
      logic [1:0] sm;
      logic rmw, com;
      logic [5:0] line;
      logic [3:0] page;
      logic [7:0] col;
      logic test;
      logic [1:0] boost;
   } slfe_cfg_t;
   typedef struct packed {
      logic [1:0] sel;
      logic [43:0] val;
   } slfe_note_t;

   logic CLK = 1'h0, RESET_N = 1'h0, SCL, CS_N, SDI, DATA_COMMAND_SELECT;
   logic [3:0] REFRESH_PAGE = 4'h0, PAGE_ADDR;
   logic [7:0] REFRESH_SEG = 8'h00, REFRESH_DATA, COL_ADDR;
   logic DISPLAY_ON, DISPLAY_INVERSE, SEG_REVERSE, ALL_POINTS_ON, BIAS_SEL;
   logic [2:0] POWER_CTRL, RESISTOR_RATIO;
   logic [5:0] VOLUME, START_LINE;
   logic [1:0] STATIC_MODE, BOOSTER;
   logic VOLUME_MODE, STATIC_ON, RMW_ON, COM_REVERSE, TEST_MODE;
   logic LINE_LATCH_PULSE, LCD_POLARITY_TOGGLE, STATIC_DRIVE_PHASE, BLANKING_OUTPUT;
   slfe_cfg_t obs_cfg, e;
   slfe_note_t notes[$];
   logic look = 1'h0;
   int failures = 0;
   int n_tests = 0;
   integer seed = 32'h7bcd;
   logic [7:0] d[4];
   logic [7:0] seq[20] = '{8'haf, 8'ha7, 8'ha1, 8'ha5, 8'ha3, 8'h2f, 8'h27, 8'h81, 8'h3f,
      8'had, 8'h02, 8'he0, 8'hc8, 8'h7f, 8'hb3, 8'h15, 8'h07, 8'hf8, 8'h03, 8'hf1};

   assign obs_cfg = {DISPLAY_ON, DISPLAY_INVERSE, SEG_REVERSE, ALL_POINTS_ON, BIAS_SEL,
      POWER_CTRL, RESISTOR_RATIO, VOLUME, VOLUME_MODE, STATIC_ON, STATIC_MODE, RMW_ON,
      COM_REVERSE, START_LINE, PAGE_ADDR, COL_ADDR, TEST_MODE, BOOSTER};

   always #50 CLK = ~CLK;

   slfe_host_model slfe_host_model_i (.scl(SCL), .cs_n(CS_N), .sdi(SDI),
      .dc(DATA_COMMAND_SELECT));

   slfe_frontend #(.LINE_CYCLES(4)) slfe_frontend_i (.CLK(CLK), .RESET_N(RESET_N),
      .SCL(SCL), .CS_N(CS_N), .SDI(SDI), .DATA_COMMAND_SELECT(DATA_COMMAND_SELECT),
      .REFRESH_PAGE(REFRESH_PAGE), .REFRESH_SEG(REFRESH_SEG), .REFRESH_DATA(REFRESH_DATA),
      .DISPLAY_ON(DISPLAY_ON), .DISPLAY_INVERSE(DISPLAY_INVERSE), .SEG_REVERSE(SEG_REVERSE),
      .ALL_POINTS_ON(ALL_POINTS_ON), .BIAS_SEL(BIAS_SEL), .POWER_CTRL(POWER_CTRL),
      .RESISTOR_RATIO(RESISTOR_RATIO), .VOLUME(VOLUME), .VOLUME_MODE(VOLUME_MODE),
      .STATIC_ON(STATIC_ON), .STATIC_MODE(STATIC_MODE), .RMW_ON(RMW_ON),
      .COM_REVERSE(COM_REVERSE), .START_LINE(START_LINE), .PAGE_ADDR(PAGE_ADDR),
      .COL_ADDR(COL_ADDR), .TEST_MODE(TEST_MODE), .BOOSTER(BOOSTER),
      .LINE_LATCH_PULSE(LINE_LATCH_PULSE), .LCD_POLARITY_TOGGLE(LCD_POLARITY_TOGGLE),
      .STATIC_DRIVE_PHASE(STATIC_DRIVE_PHASE), .BLANKING_OUTPUT(BLANKING_OUTPUT));

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude

   // The watcher compares at the falling edge so the outputs have settled.
   task automatic note(input logic [1:0] sel, input logic [43:0] val);
      @(posedge CLK);
      notes.push_back('{sel, val});
      look <= 1'h1;
      @(posedge CLK);
      look <= 1'h0;
   endtask : note

   // The core needs at most three clocks after the eighth rise.
   task automatic xfer(input logic [7:0] b, input logic is_data, input logic last);
      slfe_host_model_i.send(b, is_data, last);
      repeat (4) @(posedge CLK);
   endtask : xfer

   task automatic rd(input logic [3:0] p, input logic [7:0] s, input logic [7:0] x);
      @(posedge CLK);
      REFRESH_PAGE <= p;
      REFRESH_SEG <= s;
      note(2'h1, {36'h0, x});
   endtask : rd

   always @(negedge CLK) begin
      slfe_note_t n;
      logic [43:0] got;
      if (look) begin
         if (notes.size() == 0) begin
            failures++;
            $display("wrong value at %0t: result without a note", $time);
         end else begin
            n = notes.pop_front();
            got = (n.sel == 2'h0) ? obs_cfg : (n.sel == 2'h1) ? {36'h0, REFRESH_DATA} :
               {40'h0, LINE_LATCH_PULSE, LCD_POLARITY_TOGGLE, STATIC_DRIVE_PHASE,
               BLANKING_OUTPUT};
            n_tests++;
            if (got !== n.val) begin
               failures++;
               $display("wrong value at %0t: kind %0d got %h want %h", $time, n.sel, got, n.val);
            end
         end
      end
   end

   initial begin
      repeat (20000) @(posedge CLK);
      failures++;
      $display("wrong value at %0t: run did not finish", $time);
      conclude();
   end

   initial begin
      repeat (8) @(posedge CLK);
      note(2'h2, 44'h0_0000_0000_f);
      repeat (8) @(posedge CLK);
      RESET_N <= 1'h1;
      e = '0;
      e.vol = slfe_pkg::VOL_DEFAULT;
      repeat (2) @(posedge CLK);
      note(2'h0, e);
      for (int i = 0; i < 20; i++) xfer(seq[i], 1'h0, i == 19);
      e = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 3'h7, 3'h7, 6'h3f, 1'h0, 1'h1, 2'h2, 1'h1, 1'h1,
         6'h3f, 4'h3, 8'h57, 1'h1, 2'h3};
      note(2'h0, e);
      xfer(8'h81, 1'h0, 1'h1);
      e.vm = 1'h1;
      note(2'h0, e);
      xfer(8'h3f, 1'h0, 1'h1);
      e.vm = 1'h0;
      xfer(8'he2, 1'h0, 1'h1);
      e = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 3'h7, 3'h7, 6'h20, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0,
         6'h00, 4'h0, 8'h00, 1'h0, 2'h3};
      note(2'h0, e);
      xfer(8'ha0, 1'h0, 1'h0);
      xfer(8'hb2, 1'h0, 1'h0);
      xfer(8'h18, 1'h0, 1'h0);
      xfer(8'h00, 1'h0, 1'h1);
      for (int i = 0; i < 4; i++) begin
         d[i] = 8'($random(seed));
         xfer(d[i], 1'h1, i == 3);
      end
      e.rev = 1'h0;
      e.page = 4'h2;
      e.col = 8'h83;
      note(2'h0, e);
      for (int i = 0; i < 4; i++) rd(4'h2, 8'h80 + 8'(i), d[i]);
      xfer(8'ha1, 1'h0, 1'h1);
      for (int i = 0; i < 4; i++) rd(4'h2, 8'h03 - 8'(i), d[i]);
      xfer(8'hb8, 1'h0, 1'h1);
      xfer(8'h10, 1'h0, 1'h1);
      xfer(8'h00, 1'h0, 1'h1);
      xfer(8'hff, 1'h1, 1'h1);
      rd(4'h8, 8'h83, 8'h01);
      slfe_host_model_i.partial();
      xfer(8'hae, 1'h0, 1'h1);
      e.rev = 1'h1;
      e.page = 4'h8;
      e.col = 8'h01;
      e.on = 1'h0;
      note(2'h0, e);
      repeat (4) @(posedge CLK);
      conclude();
   end
endmodule : serial_lcd_ram_frontend_tb
